// ==== ddr3_cal_pkg.sv ====
// Package of mode-register fields, commands and constants for the calibration block
package ddr3_cal_pkg;
  // ************************************************************
  // Bus widths, burst beats and array depth
  // ************************************************************
  localparam int ADDR_W  = 14;
  localparam int BANK_W  = 3;
  localparam int DQ_W    = 16;
  localparam int BEATS   = 8;
  localparam int LAT_W   = 6;
  localparam int ARR_AW  = 4;
  localparam int ARR_DEPTH = 16;

  // ************************************************************
  // Mode register selects and fields, lane, beat and address bit indices
  // ************************************************************
  localparam logic [2:0] BANK_MR0 = 3'h0;
  localparam logic [2:0] BANK_MR1 = 3'h1;
  localparam logic [2:0] BANK_MR2 = 3'h2;
  localparam logic [2:0] BANK_MR3 = 3'h3;
  localparam int MR2_WTERM_LO = 9;
  localparam int MR2_WTERM_HI = 10;
  localparam int MR3_PAT_EN   = 2;
  localparam int MR3_FUNC_LO  = 0;
  localparam int MR3_FUNC_HI  = 1;
  localparam int MR0_BL_LO    = 0;
  localparam int MR0_BL_HI    = 1;
  localparam int MR1_LEVEL    = 7;
  localparam int MR1_NOM_B0   = 2;
  localparam int MR1_NOM_B1   = 6;
  localparam int MR1_NOM_B2   = 9;
  localparam int DQ_PRIME_LO  = 0;
  localparam int DQ_PRIME_HI  = 8;
  localparam logic [2:0] BEAT_FIRST    = 3'h0;
  localparam logic [2:0] BEAT_HI_START = 3'h4;
  localparam logic [2:0] BEAT_LO_END   = 3'h3;
  localparam logic [2:0] BEAT_END      = 3'h7;
  localparam int A_BC_OTF     = 12;
  localparam int A_NIBBLE     = 2;
  localparam logic [1:0] FUNC_PREDEF = 2'h0;
  localparam logic [1:0] WTERM_OFF   = 2'h0;
  localparam logic [1:0] BL_FIXED8   = 2'h0;
  localparam logic [1:0] BL_OTF      = 2'h1;
  localparam logic [1:0] BL_FIXED4   = 2'h2;
  localparam logic [2:0] NOM_OFF     = 3'h0;

  // ************************************************************
  // Predefined pattern, beat 0 in the least significant bit
  // ************************************************************
  localparam logic [7:0] PAT_PREDEF = 8'hAA;

  // ************************************************************
  // Command encoding
  // ************************************************************
  typedef enum logic [2:0] {
    CMD_NOP, CMD_MRS, CMD_READ, CMD_READ_WITH_AUTO_PRECHARGE, CMD_WRITE, CMD_OTHER
  } cmd_t;

  // Termination presented on the data lines
  typedef enum logic [1:0] {
    TERM_HIGHZ, TERM_NOM, TERM_WR
  } term_sel_t;
endpackage

// ==== ddr3_beat_buf.sv ====
// Two-entry valid/ready buffer for outgoing read beats
`timescale 1ns/1ps
module ddr3_beat_buf (
  input  wire logic                          mclk,
  input  wire logic                          resetn,
  input  wire logic                          in_valid,
  output logic                               in_ready,
  input  wire logic [ddr3_cal_pkg::DQ_W-1:0] in_data,
  output logic                               out_valid,
  input  wire logic                          out_ready,
  output logic      [ddr3_cal_pkg::DQ_W-1:0] out_data
);
  logic [ddr3_cal_pkg::DQ_W-1:0] mem_ff [2];
  logic                          wptr_ff;
  logic                          rptr_ff;
  logic [1:0]                    cnt_ff;
  logic                          push;
  logic                          pop;

  assign in_ready  = (cnt_ff != 2'h2);
  assign out_valid = (cnt_ff != 2'h0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_ff[rptr_ff];

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      mem_ff[0] <= '0;
      mem_ff[1] <= '0;
    end else if (push) begin
      mem_ff[wptr_ff] <= in_data;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wptr_ff <= 1'b0;
      rptr_ff <= 1'b0;
      cnt_ff  <= 2'h0;
    end else begin
      if (push) wptr_ff <= ~wptr_ff;
      if (pop) rptr_ff <= ~rptr_ff;
      cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// ==== ddr3_mpr_odt.sv ====
// Dynamic write termination and calibration pattern readout logic
//
// Notes on behaviour
// - Write termination field is mode register two bits 10:9; nonzero enables.
// - Write termination replaces nominal during each write burst outside pattern mode, then reverts.
// - Nominal disabled gives high impedance; both settings act independently.
// - No write termination switching while write leveling is active.
// - Mode register three keeps its value until rewritten; array untouched.
// - Bit 2 clear means normal array access; bits 1:0 ignored.
// - Bit 2 set redirects reads and auto-precharge reads to pattern.
// - Function 00 selects predefined pattern; other codes give no readout.
// - Reset is honoured while pattern mode is on.
// - Pattern on prime lines with others low, or on all lines.
// - Eight-beat and four-beat chop supported, fixed or by address bit 12.
// - Chop reads return beats 0-3 or 4-7 by address bit 2.
// - Pattern alternates 0,1 starting with 0.
// - First beat from pattern LSB, last beat from MSB.
// - Other address and bank bits ignored; bit 12 only when enabled.
// - Back-to-back reads each return the pattern until mode cleared.
// - Burst starts after read latency of additive plus column latency.
`timescale 1ns/1ps
module ddr3_mpr_odt (
  input  wire logic                            mclk,
  input  wire logic                            resetn,
  input  wire ddr3_cal_pkg::cmd_t              cmd,
  input  wire logic [ddr3_cal_pkg::BANK_W-1:0] bank,
  input  wire logic [ddr3_cal_pkg::ADDR_W-1:0] addr,
  input  wire logic [ddr3_cal_pkg::LAT_W-1:0]  read_latency,
  input  wire logic [ddr3_cal_pkg::LAT_W-1:0]  write_latency,
  input  wire logic                            pattern_all_lines,
  input  wire logic                            wide_part,
  input  wire logic                            dll_locked,
  input  wire logic [ddr3_cal_pkg::DQ_W-1:0]   array_rdata,
  output logic                                 array_read,
  output logic                                 array_write,
  output logic      [ddr3_cal_pkg::ADDR_W-1:0] array_addr,
  output logic                                 dq_valid,
  input  wire logic                            dq_ready,
  output logic      [ddr3_cal_pkg::DQ_W-1:0]   dq_out,
  output ddr3_cal_pkg::term_sel_t              term_sel,
  output logic      [1:0]                      wterm_value,
  output logic                                 pattern_mode
);
  // ************************************************************
  // Mode registers
  // ************************************************************
  logic [ddr3_cal_pkg::ADDR_W-1:0] mr0_ff;
  logic [ddr3_cal_pkg::ADDR_W-1:0] mr1_ff;
  logic [ddr3_cal_pkg::ADDR_W-1:0] mr2_ff;
  logic [2:0]                      mode_register_three_ff;
  logic                            mrs;

  assign mrs = (cmd == ddr3_cal_pkg::CMD_MRS);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      mr0_ff                 <= '0;
      mr1_ff                 <= '0;
      mr2_ff                 <= '0;
      mode_register_three_ff <= '0;
    end else if (mrs) begin
      case (bank)
        ddr3_cal_pkg::BANK_MR0: mr0_ff <= addr;
        ddr3_cal_pkg::BANK_MR1: mr1_ff <= addr;
        ddr3_cal_pkg::BANK_MR2: mr2_ff <= addr;
        ddr3_cal_pkg::BANK_MR3: mode_register_three_ff <= addr[2:0];
        default: mr0_ff <= mr0_ff;
      endcase
    end
  end

  logic       pat_en;
  logic       pat_predef;
  logic [1:0] wterm_field;
  logic       leveling;
  logic [2:0] nom_field;

  assign pat_en      = mode_register_three_ff[ddr3_cal_pkg::MR3_PAT_EN];
  assign pat_predef  = pat_en && (mode_register_three_ff[ddr3_cal_pkg::MR3_FUNC_HI:
                       ddr3_cal_pkg::MR3_FUNC_LO] == ddr3_cal_pkg::FUNC_PREDEF);
  assign wterm_field = mr2_ff[ddr3_cal_pkg::MR2_WTERM_HI:ddr3_cal_pkg::MR2_WTERM_LO];
  assign leveling    = mr1_ff[ddr3_cal_pkg::MR1_LEVEL];
  assign nom_field   = {mr1_ff[ddr3_cal_pkg::MR1_NOM_B2], mr1_ff[ddr3_cal_pkg::MR1_NOM_B1],
                        mr1_ff[ddr3_cal_pkg::MR1_NOM_B0]};
  assign pattern_mode = pat_en;
  assign wterm_value  = wterm_field;

  // ************************************************************
  // Array path, normal mode only
  // ************************************************************
  logic is_read;
  logic is_write;

  assign is_read  = (cmd == ddr3_cal_pkg::CMD_READ) || (cmd == ddr3_cal_pkg::CMD_READ_WITH_AUTO_PRECHARGE);
  assign is_write = (cmd == ddr3_cal_pkg::CMD_WRITE);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      array_read  <= 1'b0;
      array_write <= 1'b0;
      array_addr  <= '0;
    end else begin
      array_read  <= is_read && !pat_en;
      array_write <= is_write && !pat_en;
      array_addr  <= addr;
    end
  end

  // ************************************************************
  // Read burst sizing
  // ************************************************************
  logic       chop;
  logic [1:0] bl_field;

  assign bl_field = mr0_ff[ddr3_cal_pkg::MR0_BL_HI:ddr3_cal_pkg::MR0_BL_LO];
  always_comb begin
    case (bl_field)
      ddr3_cal_pkg::BL_FIXED4: chop = 1'b1;
      ddr3_cal_pkg::BL_OTF:    chop = !addr[ddr3_cal_pkg::A_BC_OTF];
      default:                 chop = 1'b0;
    endcase
  end

  // ************************************************************
  // Latency pipeline: command info delayed by read latency
  // ************************************************************
  localparam int LAT_MAX = 2 ** ddr3_cal_pkg::LAT_W;
  logic [LAT_MAX-1:0] rd_pipe_ff;
  logic [LAT_MAX-1:0] ch_pipe_ff;
  logic [LAT_MAX-1:0] hi_pipe_ff;
  logic [LAT_MAX-1:0] pt_pipe_ff;
  logic               rd_issue;

  assign rd_issue = is_read && dll_locked && (!pat_en || pat_predef);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rd_pipe_ff <= '0;
      ch_pipe_ff <= '0;
      hi_pipe_ff <= '0;
      pt_pipe_ff <= '0;
    end else begin
      rd_pipe_ff <= {rd_pipe_ff[LAT_MAX-2:0], rd_issue};
      ch_pipe_ff <= {ch_pipe_ff[LAT_MAX-2:0], chop};
      hi_pipe_ff <= {hi_pipe_ff[LAT_MAX-2:0], chop && addr[ddr3_cal_pkg::A_NIBBLE]};
      pt_pipe_ff <= {pt_pipe_ff[LAT_MAX-2:0], pat_en};
    end
  end

  logic lat_hit;
  logic lat_chop;
  logic lat_hi;
  logic lat_pat;
  logic [ddr3_cal_pkg::LAT_W-1:0] lat_idx;

  assign lat_idx  = (read_latency == '0) ? '0 : read_latency - ddr3_cal_pkg::LAT_W'(1);
  assign lat_hit  = rd_pipe_ff[lat_idx];
  assign lat_chop = ch_pipe_ff[lat_idx];
  assign lat_hi   = hi_pipe_ff[lat_idx];
  assign lat_pat  = pt_pipe_ff[lat_idx];

  // ************************************************************
  // Burst sequencer
  // ************************************************************
  typedef enum logic [1:0] {ST_IDLE, ST_BURST} burst_st_t;
  burst_st_t  st_ff;
  logic [2:0] beat_ff;
  logic [2:0] last_ff;
  logic       src_pat_ff;
  logic       stall;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_ff      <= ST_IDLE;
      beat_ff    <= '0;
      last_ff    <= '0;
      src_pat_ff <= 1'b0;
    end else if (lat_hit) begin
      // A new burst always restarts; back-to-back reads chain seamlessly
      st_ff      <= ST_BURST;
      beat_ff    <= lat_hi ? ddr3_cal_pkg::BEAT_HI_START : ddr3_cal_pkg::BEAT_FIRST;
      last_ff    <= (lat_chop && !lat_hi) ? ddr3_cal_pkg::BEAT_LO_END : ddr3_cal_pkg::BEAT_END;
      src_pat_ff <= lat_pat;
    end else begin
      case (st_ff)
        ST_BURST: begin
          if (!stall) begin
            if (beat_ff == last_ff) st_ff <= ST_IDLE;
            else beat_ff <= beat_ff + 3'h1;
          end
        end
        default: st_ff <= ST_IDLE;
      endcase
    end
  end

  // ************************************************************
  // Beat data formation
  // ************************************************************
  logic                          buf_in_ready;
  logic                          beat_valid;
  logic [ddr3_cal_pkg::DQ_W-1:0] beat_data;
  logic                          pat_bit;

  assign beat_valid = (st_ff == ST_BURST);
  assign stall      = !buf_in_ready;
  assign pat_bit    = ddr3_cal_pkg::PAT_PREDEF[beat_ff];

  generate
    for (genvar i = 0; i < ddr3_cal_pkg::DQ_W; i++) begin : g_lane
      always_comb begin
        if (!src_pat_ff)
          beat_data[i] = array_rdata[i];
        else if (pattern_all_lines || i == ddr3_cal_pkg::DQ_PRIME_LO ||
                 (wide_part && i == ddr3_cal_pkg::DQ_PRIME_HI))
          beat_data[i] = pat_bit;
        else
          beat_data[i] = 1'b0;
      end
    end
  endgenerate

  ddr3_beat_buf ddr3_beat_buf_inst (
    .mclk      (mclk),
    .resetn    (resetn),
    .in_valid  (beat_valid),
    .in_ready  (buf_in_ready),
    .in_data   (beat_data),
    .out_valid (dq_valid),
    .out_ready (dq_ready),
    .out_data  (dq_out)
  );

  // ************************************************************
  // Termination control
  // ************************************************************
  logic [ddr3_cal_pkg::LAT_W-1:0] wr_cnt_ff;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wr_cnt_ff <= '0;
    end else if (is_write && !pat_en) begin
      wr_cnt_ff <= write_latency + ddr3_cal_pkg::LAT_W'(ddr3_cal_pkg::BEATS);
    end else if (wr_cnt_ff != '0) begin
      wr_cnt_ff <= wr_cnt_ff - ddr3_cal_pkg::LAT_W'(1);
    end
  end

  always_comb begin
    if (wr_cnt_ff != '0 && wterm_field != ddr3_cal_pkg::WTERM_OFF && !leveling)
      term_sel = ddr3_cal_pkg::TERM_WR;
    else if (nom_field == ddr3_cal_pkg::NOM_OFF)
      term_sel = ddr3_cal_pkg::TERM_HIGHZ;
    else
      term_sel = ddr3_cal_pkg::TERM_NOM;
  end

  // ************************************************************
  // Checks
  // ************************************************************
  property p_pat_no_array;
    @(posedge mclk) disable iff (!resetn)
      (pat_en && is_read) |=> !array_read;
  endproperty
  a_pat_no_array: assert property (p_pat_no_array) else $error("array read in pattern mode");

  property p_norm_array;
    @(posedge mclk) disable iff (!resetn)
      (!pat_en && is_read) |=> array_read;
  endproperty
  a_norm_array: assert property (p_norm_array) else $error("normal read missed array");

  property p_leveling_no_wr;
    @(posedge mclk) disable iff (!resetn)
      leveling |-> term_sel != ddr3_cal_pkg::TERM_WR;
  endproperty
  a_leveling_no_wr: assert property (p_leveling_no_wr) else $error("switch in leveling");

  property p_wterm_off;
    @(posedge mclk) disable iff (!resetn)
      (wterm_field == ddr3_cal_pkg::WTERM_OFF) |-> term_sel != ddr3_cal_pkg::TERM_WR;
  endproperty
  a_wterm_off: assert property (p_wterm_off) else $error("write term while off");

  property p_write_switch;
    @(posedge mclk) disable iff (!resetn)
      (is_write && !pat_en && !leveling && wterm_field != ddr3_cal_pkg::WTERM_OFF && !mrs)
      |=> term_sel == ddr3_cal_pkg::TERM_WR;
  endproperty
  a_write_switch: assert property (p_write_switch) else $error("no write term");

  property p_pattern_bit;
    @(posedge mclk) disable iff (!resetn)
      (beat_valid && src_pat_ff) |-> beat_data[0] == beat_ff[0];
  endproperty
  a_pattern_bit: assert property (p_pattern_bit) else $error("pattern bit wrong");

  property p_prime_low;
    @(posedge mclk) disable iff (!resetn)
      (beat_valid && src_pat_ff && !pattern_all_lines) |-> beat_data[7:1] == '0;
  endproperty
  a_prime_low: assert property (p_prime_low) else $error("non-prime line high");

  property p_burst_len;
    @(posedge mclk) disable iff (!resetn)
      (lat_hit && !lat_chop && buf_in_ready) ##1 (buf_in_ready && !lat_hit) [*8]
      |=> st_ff == ST_IDLE;
  endproperty
  a_burst_len: assert property (p_burst_len) else $error("eight-beat length wrong");

  property p_reset_clears;
    @(posedge mclk) $rose(resetn) |-> !pat_en;
  endproperty
  a_reset_clears: assert property (p_reset_clears) else $error("pattern mode kept over reset");
endmodule

// ==== mem_ctrl_model.sv ====
// Controller-side model: commands, array data and receiver readiness
`timescale 1ns/1ps
module mem_ctrl_model (
  input  wire logic                            mclk,
  input  wire logic                            stall_en,
  output ddr3_cal_pkg::cmd_t                   cmd,
  output logic      [ddr3_cal_pkg::BANK_W-1:0] bank,
  output logic      [ddr3_cal_pkg::ADDR_W-1:0] addr,
  output logic      [ddr3_cal_pkg::DQ_W-1:0]   array_rdata,
  output logic                                 dq_ready
);
  localparam int MOD_GAP = 12;
  logic [1:0] stall_cnt = 2'h0;
  logic       pat_on    = 1'b0;
  initial begin
    cmd = ddr3_cal_pkg::CMD_NOP;
    bank = 3'h0;
    addr = 14'h0000;
    dq_ready = 1'b1;
  end
  assign array_rdata = 16'hC3A5;
  // Receiver stalls two cycles in four when asked
  always @(negedge mclk) begin
    stall_cnt <= stall_cnt + 2'h1;
    dq_ready  <= !(stall_en && stall_cnt[1]);
  end
  // One command cycle, then NOP with bank and address showing the inverse of the last value
  task automatic issue(ddr3_cal_pkg::cmd_t c, logic [2:0] b, logic [13:0] a);
    cmd = c;
    bank = b;
    addr = a;
    @(negedge mclk);
    cmd = ddr3_cal_pkg::CMD_NOP;
    bank = ~b;
    addr = ~a;
  endtask
  task automatic mrs(logic [2:0] b, logic [13:0] a);
    issue(ddr3_cal_pkg::CMD_MRS, b, a);
    repeat (MOD_GAP) @(negedge mclk);
  endtask
  task automatic mr3(logic [13:0] a);
    pat_on = a[2];
    mrs(ddr3_cal_pkg::BANK_MR3, a & 14'h0007);
  endtask
  task automatic rd(ddr3_cal_pkg::cmd_t k, logic [13:0] a, logic [2:0] b);
    issue(k, b, {a[13:2], 2'h0});
  endtask
  task automatic wr();
    if (!pat_on) issue(ddr3_cal_pkg::CMD_WRITE, 3'h0, 14'h0000);
  endtask
endmodule

// ==== ddr3_mpr_odt_bench.sv ====
// Self-checking bench for termination switching and pattern readout
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module ddr3_mpr_odt_bench;
  logic                    mclk = 1'b0;
  logic                    resetn = 1'b0;
  ddr3_cal_pkg::cmd_t      cmd;
  logic [2:0]              bank;
  logic [13:0]             addr;
  logic [5:0]              read_latency = 6'h05;
  logic [5:0]              write_latency = 6'h04;
  logic                    all_lines = 1'b0;
  logic                    wide_part = 1'b0;
  logic                    dll_locked = 1'b1;
  logic                    stall_en = 1'b0;
  logic [15:0]             array_rdata;
  logic                    array_read;
  logic                    array_write;
  logic [13:0]             array_addr;
  logic                    dq_valid;
  logic                    dq_ready;
  logic [15:0]             dq_out;
  ddr3_cal_pkg::term_sel_t term_sel;
  logic [1:0]              wterm_value;
  logic                    pattern_mode;
  int                      error_cnt = 0;
  int                      samples_checked = 0;
  int                      arr_rd_cnt = 0;
  int                      arr_wr_cnt = 0;
  int                      last_lat;
  int                      lat5;
  int                      n0;
  logic [13:0]             arr_addr_seen;
  logic [15:0]             got_q [$];
  logic [13:0]             t_mr1 [4] = '{14'h0004, 14'h0004, 14'h0000, 14'h0084};
  logic [13:0]             t_mr2 [4] = '{14'h0200, 14'h0000, 14'h0400, 14'h0600};
  int                      t_wr [4] = '{12, 0, 12, 0};
  ddr3_cal_pkg::term_sel_t t_idle [4] = '{ddr3_cal_pkg::TERM_NOM, ddr3_cal_pkg::TERM_NOM,
                                          ddr3_cal_pkg::TERM_HIGHZ, ddr3_cal_pkg::TERM_NOM};
  always #2 mclk = ~mclk;
  ddr3_mpr_odt ddr3_mpr_odt_inst (.mclk(mclk), .resetn(resetn), .cmd(cmd), .bank(bank),
    .addr(addr), .read_latency(read_latency), .write_latency(write_latency),
    .pattern_all_lines(all_lines), .wide_part(wide_part), .dll_locked(dll_locked),
    .array_rdata(array_rdata), .array_read(array_read), .array_write(array_write),
    .array_addr(array_addr), .dq_valid(dq_valid), .dq_ready(dq_ready), .dq_out(dq_out),
    .term_sel(term_sel), .wterm_value(wterm_value), .pattern_mode(pattern_mode));
  mem_ctrl_model mem_ctrl_model_inst (.mclk(mclk), .stall_en(stall_en), .cmd(cmd),
    .bank(bank), .addr(addr), .array_rdata(array_rdata), .dq_ready(dq_ready));
  always @(posedge mclk) begin
    if (array_read === 1'b1) begin
      arr_rd_cnt++;
      arr_addr_seen = array_addr;
    end
    if (array_write === 1'b1) arr_wr_cnt++;
  end
  // ************************************************************
  // Helpers
  // ************************************************************
  task automatic wrap_up();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  function automatic logic [15:0] exp_word(int s, int i);
    logic b;
    if (s < 0) return 16'hC3A5;
    b = ddr3_cal_pkg::PAT_PREDEF[s + i];
    return all_lines ? {16{b}} : {7'h00, wide_part & b, 7'h00, b};
  endfunction
  task automatic collect(int n);
    int k;
    k = 0;
    last_lat = -1;
    got_q.delete();
    while (got_q.size() < n && k < 200) begin
      @(negedge mclk);
      // Sample after the receiver's falling-edge ready update
      #1;
      k++;
      if (dq_valid === 1'b1 && dq_ready === 1'b1) begin
        if (last_lat < 0) last_lat = k;
        got_q.push_back(dq_out);
      end
    end
    if (got_q.size() < n) begin
      error_cnt++;
      $display("ERROR beats exp %0d got %0d", n, got_q.size());
      wrap_up();
    end
  endtask
  task automatic quiet();
    int v;
    v = 0;
    repeat (14) begin
      @(negedge mclk);
      if (dq_valid !== 1'b0) v++;
    end
    `CHK("no_burst", 0, v)
  endtask
  task automatic rd_check(ddr3_cal_pkg::cmd_t k, logic [13:0] a, logic [2:0] b, int n, int s);
    fork
      mem_ctrl_model_inst.rd(k, a, b);
      collect(n);
    join
    for (int i = 0; i < n; i++) `CHK("beat", exp_word(s, i), got_q[i])
    quiet();
  endtask
  task automatic set_len(logic [13:0] a);
    mem_ctrl_model_inst.mr3(14'h0000);
    mem_ctrl_model_inst.mrs(ddr3_cal_pkg::BANK_MR0, a);
    mem_ctrl_model_inst.mr3(14'h0004);
  endtask
  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    repeat (5) @(negedge mclk);
    resetn = 1'b1;
    @(negedge mclk);
    `CHK("rst_pattern", 1'b0, pattern_mode)
    `CHK("rst_term", ddr3_cal_pkg::TERM_HIGHZ, term_sel)
    `CHK("rst_valid", 1'b0, dq_valid)
    for (int t = 0; t < 4; t++) begin
      mem_ctrl_model_inst.mrs(ddr3_cal_pkg::BANK_MR1, t_mr1[t]);
      mem_ctrl_model_inst.mrs(ddr3_cal_pkg::BANK_MR2, t_mr2[t]);
      `CHK("wterm", t_mr2[t][10:9], wterm_value)
      `CHK("term_idle", t_idle[t], term_sel)
      mem_ctrl_model_inst.wr();
      n0 = 0;
      repeat (20) begin
        if (term_sel === ddr3_cal_pkg::TERM_WR) n0++;
        @(negedge mclk);
      end
      `CHK("term_wr_cycles", t_wr[t], n0)
      `CHK("term_after", t_idle[t], term_sel)
    end
    mem_ctrl_model_inst.mrs(ddr3_cal_pkg::BANK_MR0, 14'h0000);
    mem_ctrl_model_inst.mr3(14'h0003);
    `CHK("pattern_off", 1'b0, pattern_mode)
    n0 = arr_rd_cnt;
    rd_check(ddr3_cal_pkg::CMD_READ, 14'h0040, 3'h1, 8, -1);
    `CHK("arr_reads", n0 + 1, arr_rd_cnt)
    `CHK("arr_addr", 14'h0040, arr_addr_seen)
    n0 = arr_wr_cnt;
    mem_ctrl_model_inst.wr();
    repeat (3) @(negedge mclk);
    `CHK("arr_writes", n0 + 1, arr_wr_cnt)
    mem_ctrl_model_inst.mr3(14'h0004);
    `CHK("pattern_on", 1'b1, pattern_mode)
    n0 = arr_rd_cnt;
    rd_check(ddr3_cal_pkg::CMD_READ, 14'h0000, 3'h0, 8, 0);
    lat5 = last_lat;
    `CHK("lat_window", 1'b1, (lat5 == 6 || lat5 == 7))
    rd_check(ddr3_cal_pkg::CMD_READ_WITH_AUTO_PRECHARGE, 14'h2FF8, 3'h7, 8, 0);
    `CHK("arr_untouched", n0, arr_rd_cnt)
    set_len(14'h0002);
    rd_check(ddr3_cal_pkg::CMD_READ, 14'h0000, 3'h0, 4, 0);
    rd_check(ddr3_cal_pkg::CMD_READ, 14'h0004, 3'h0, 4, 4);
    set_len(14'h0001);
    rd_check(ddr3_cal_pkg::CMD_READ, 14'h0004, 3'h0, 4, 4);
    rd_check(ddr3_cal_pkg::CMD_READ, 14'h1000, 3'h0, 8, 0);
    all_lines = 1'b1;
    rd_check(ddr3_cal_pkg::CMD_READ, 14'h1000, 3'h0, 8, 0);
    all_lines = 1'b0;
    wide_part = 1'b1;
    rd_check(ddr3_cal_pkg::CMD_READ, 14'h1000, 3'h0, 8, 0);
    fork
      begin
        mem_ctrl_model_inst.rd(ddr3_cal_pkg::CMD_READ, 14'h1000, 3'h0);
        repeat (7) @(negedge mclk);
        mem_ctrl_model_inst.rd(ddr3_cal_pkg::CMD_READ_WITH_AUTO_PRECHARGE, 14'h1000, 3'h0);
      end
      collect(16);
    join
    for (int i = 0; i < 16; i++) `CHK("b2b_beat", exp_word(0, i % 8), got_q[i])
    quiet();
    stall_en = 1'b1;
    rd_check(ddr3_cal_pkg::CMD_READ, 14'h1000, 3'h0, 8, 0);
    stall_en = 1'b0;
    read_latency = 6'h09;
    rd_check(ddr3_cal_pkg::CMD_READ, 14'h1000, 3'h0, 8, 0);
    `CHK("lat_step", 4, last_lat - lat5)
    read_latency = 6'h05;
    for (int f = 1; f < 4; f++) begin
      mem_ctrl_model_inst.mr3(14'h0004 | f[13:0]);
      mem_ctrl_model_inst.rd(ddr3_cal_pkg::CMD_READ, 14'h1000, 3'h0);
      quiet();
    end
    mem_ctrl_model_inst.mr3(14'h0004);
    dll_locked = 1'b0;
    mem_ctrl_model_inst.rd(ddr3_cal_pkg::CMD_READ, 14'h1000, 3'h0);
    quiet();
    dll_locked = 1'b1;
    `CHK("pattern_kept", 1'b1, pattern_mode)
    resetn = 1'b0;
    repeat (2) @(negedge mclk);
    `CHK("rst_in_pattern", 1'b0, pattern_mode)
    resetn = 1'b1;
    @(negedge mclk);
    `CHK("rst_valid2", 1'b0, dq_valid)
    wrap_up();
  end
  initial begin
    repeat (20000) @(negedge mclk);
    error_cnt++;
    $display("ERROR watchdog exp done got stuck");
    wrap_up();
  end
endmodule
